//--- sbp_pkg.sv
// Constants for the status bit packing words
package sbp_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned IO_STATES = 64;
  localparam int unsigned IO_WORDS = IO_STATES / WORD_W;
  localparam int unsigned LAMPS = 8;
  localparam int unsigned ELEM_COUNT = 256;
  localparam int unsigned ELEM_WORDS = ELEM_COUNT / WORD_W;
  localparam int unsigned ELEM_IDX_W = 4;
  localparam int unsigned IO_IDX_W = 2;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] LAMP_PAD = 8'h00;
endpackage

//--- sbp_poller.sv
// Remote master model stepping through the status words
`timescale 1ns/1ps
`default_nettype none
module sbp_poller (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [1:0] io_sel_o,
  output logic [3:0] elem_sel_o
);
  logic [3:0] addr_q;
  always_ff @(posedge clk_i) addr_q <= rst_i ? 4'h0 : addr_q + 4'h1;
  assign io_sel_o = addr_q[1:0];
  assign elem_sel_o = addr_q;
endmodule
`default_nettype wire

//--- sbp_status_words.sv
// Packs I/O, lamp and element operate states into 16-bit read-only words
`timescale 1ns/1ps
`default_nettype none
module sbp_status_words #(
  parameter int unsigned ELEMS = sbp_pkg::ELEM_COUNT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [sbp_pkg::IO_STATES-1:0] io_state_i,
  input wire logic [sbp_pkg::LAMPS-1:0] lamp_lit_i,
  input wire logic [ELEMS-1:0] elem_operate_i,
  input wire logic [sbp_pkg::IO_IDX_W-1:0] io_word_sel_i,
  input wire logic [sbp_pkg::ELEM_IDX_W-1:0] elem_word_sel_i,
  output logic [sbp_pkg::WORD_W-1:0] io_word_o,
  output logic [sbp_pkg::WORD_W-1:0] lamp_word_o,
  output logic [sbp_pkg::WORD_W-1:0] elem_word_o
);
  localparam int unsigned W = sbp_pkg::WORD_W;
  localparam int unsigned EW = sbp_pkg::ELEM_WORDS;

  // Inputs come from pins or another domain, so synchronise twice first
  // Only the second stage is read by logic; the first may be metastable
  logic [sbp_pkg::IO_STATES-1:0] io_s1_d;
  logic [sbp_pkg::IO_STATES-1:0] io_s1_q;
  logic [sbp_pkg::IO_STATES-1:0] io_s2_d;
  logic [sbp_pkg::IO_STATES-1:0] io_s2_q;

  // Reset and enable live in the next-state logic, so the flops only register
  always_comb
  begin
    io_s1_d = io_s1_q;
    io_s2_d = io_s2_q;
    if (rst_i)
    begin
      io_s1_d = '0;
      io_s2_d = '0;
    end
    else if (ce_i)
    begin
      io_s1_d = io_state_i;
      io_s2_d = io_s1_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    io_s1_q <= io_s1_d;
    io_s2_q <= io_s2_d;
  end

  // Lamp states: same two-stage treatment as the I/O states
  logic [sbp_pkg::LAMPS-1:0] lamp_s1_d;
  logic [sbp_pkg::LAMPS-1:0] lamp_s1_q;
  logic [sbp_pkg::LAMPS-1:0] lamp_s2_d;
  logic [sbp_pkg::LAMPS-1:0] lamp_s2_q;

  always_comb
  begin
    lamp_s1_d = lamp_s1_q;
    lamp_s2_d = lamp_s2_q;
    if (rst_i)
    begin
      lamp_s1_d = '0;
      lamp_s2_d = '0;
    end
    else if (ce_i)
    begin
      lamp_s1_d = lamp_lit_i;
      lamp_s2_d = lamp_s1_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    lamp_s1_q <= lamp_s1_d;
    lamp_s2_q <= lamp_s2_d;
  end

  // Operate flags: bits are synchronised one by one, so a word may mix two snapshots
  logic [ELEMS-1:0] elem_s1_d;
  logic [ELEMS-1:0] elem_s1_q;
  logic [ELEMS-1:0] elem_s2_d;
  logic [ELEMS-1:0] elem_s2_q;

  always_comb
  begin
    elem_s1_d = elem_s1_q;
    elem_s2_d = elem_s2_q;
    if (rst_i)
    begin
      elem_s1_d = '0;
      elem_s2_d = '0;
    end
    else if (ce_i)
    begin
      elem_s1_d = elem_operate_i;
      elem_s2_d = elem_s1_q;
    end
  end

  always_ff @(posedge clk_i)
  begin
    elem_s1_q <= elem_s1_d;
    elem_s2_q <= elem_s2_d;
  end

  // Flat word images built bit by bit
  logic [sbp_pkg::IO_STATES-1:0] io_flat;
  logic [EW*W-1:0] elem_flat;

  genvar g;
  generate
    for (g = 0; g < sbp_pkg::IO_STATES; g++)
    begin : g_io
      // State g+1 lands in word g/16; first state of a word takes the MSB
      assign io_flat[(g / W) * W + (W - 1 - (g % W))] = io_s2_q[g];
    end
    for (g = 0; g < EW * W; g++)
    begin : g_elem
      if (g < ELEMS)
      begin : g_used
        assign elem_flat[g] = elem_s2_q[g];
      end
      else
      begin : g_unused
        assign elem_flat[g] = 1'b0;
      end
    end
  endgenerate

  logic [W-1:0] io_sel, elem_sel;

  sbp_word_mux #(
    .WORDS(sbp_pkg::IO_WORDS),
    .IDX_W(sbp_pkg::IO_IDX_W)
  ) u_io_mux (
    .words_i(io_flat),
    .idx_i(io_word_sel_i),
    .word_o(io_sel)
  );

  sbp_word_mux #(
    .WORDS(EW),
    .IDX_W(sbp_pkg::ELEM_IDX_W)
  ) u_elem_mux (
    .words_i(elem_flat),
    .idx_i(elem_word_sel_i),
    .word_o(elem_sel)
  );

  // Selection is a pure read: no state changes because of it
  logic [W-1:0] io_word_d;
  logic [W-1:0] io_word_q;

  always_comb
  begin
    io_word_d = io_word_q;
    if (rst_i)
    begin
      io_word_d = sbp_pkg::WORD_RESET;
    end
    else if (ce_i)
    begin
      io_word_d = io_sel;
    end
  end

  always_ff @(posedge clk_i)
  begin
    io_word_q <= io_word_d;
  end

  // The lamp word has no select; its high byte is padding
  logic [W-1:0] lamp_word_d;
  logic [W-1:0] lamp_word_q;

  always_comb
  begin
    lamp_word_d = lamp_word_q;
    if (rst_i)
    begin
      lamp_word_d = sbp_pkg::WORD_RESET;
    end
    else if (ce_i)
    begin
      lamp_word_d = {sbp_pkg::LAMP_PAD, lamp_s2_q};
    end
  end

  always_ff @(posedge clk_i)
  begin
    lamp_word_q <= lamp_word_d;
  end

  logic [W-1:0] elem_word_d;
  logic [W-1:0] elem_word_q;

  always_comb
  begin
    elem_word_d = elem_word_q;
    if (rst_i)
    begin
      elem_word_d = sbp_pkg::WORD_RESET;
    end
    else if (ce_i)
    begin
      elem_word_d = elem_sel;
    end
  end

  always_ff @(posedge clk_i)
  begin
    elem_word_q <= elem_word_d;
  end

  assign io_word_o = io_word_q;
  assign lamp_word_o = lamp_word_q;
  assign elem_word_o = elem_word_q;
endmodule
`default_nettype wire

//--- sbp_status_words_assertions.sv
// Checker bound to the status word packer
`timescale 1ns/1ps
`default_nettype none
module sbp_status_words_chk #(
  parameter int unsigned ELEMS = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [63:0] io_state_i,
  input wire logic [7:0] lamp_lit_i,
  input wire logic [ELEMS-1:0] elem_operate_i,
  input wire logic [1:0] io_word_sel_i,
  input wire logic [3:0] elem_word_sel_i,
  input wire logic [15:0] io_word_o,
  input wire logic [15:0] lamp_word_o,
  input wire logic [15:0] elem_word_o
);
  // Three enabled edges cover the two sync flops and the output register
  logic [2:0] ceh_q;
  logic [15:0] io_rev;
  always_ff @(posedge clk_i) ceh_q <= {ceh_q[1:0], ce_i & ~rst_i};
  always_comb io_rev = {<<{io_word_o}};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_io_pack: assert property (&ceh_q |->
    io_rev == 16'($past(io_state_i, 3) >> {$past(io_word_sel_i), 4'h0})) else $error("io word");
  a_lamp_map: assert property (&ceh_q |->
    lamp_word_o == {8'h00, $past(lamp_lit_i, 3)}) else $error("lamp word");
  a_elem_map: assert property (&ceh_q |->
    elem_word_o == 16'($past(elem_operate_i, 3) >> {$past(elem_word_sel_i), 4'h0})) else $error("elem word");
  a_freeze_hold: assert property (!$past(ce_i) && !$past(rst_i) |->
    $stable({io_word_o, lamp_word_o, elem_word_o})) else $error("frozen word moved");
  a_lamp_pad: assert property (
    lamp_word_o[15:8] == 8'h00) else $error("lamp high byte not zero");
  a_reset_clear: assert property ($past(rst_i) |->
    {io_word_o, lamp_word_o, elem_word_o} == 48'h0) else $error("word not cleared by reset");
endmodule
bind sbp_status_words sbp_status_words_chk #(.ELEMS(ELEMS)) chk_u (.*);
`default_nettype wire

//--- sbp_status_words_tb_top.sv
// Self-checking bench for the status word packer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module sbp_status_words_tb_top;
  typedef struct {logic v; logic [15:0] io, lamp, elem;} sbp_exp_t;
  logic clk_i = 0, rst_i = 1, ce_i = 1;
  logic [63:0] io_state_i = '0;
  logic [7:0] lamp_lit_i = '0;
  logic [255:0] elem_operate_i = '0;
  logic [1:0] io_sel;
  logic [3:0] elem_sel;
  logic [15:0] io_word_o, lamp_word_o, elem_word_o, rv;
  sbp_exp_t q[$];
  sbp_exp_t e;
  int num_errors = 0, checks = 0;
  sbp_status_words dut_u (.clk_i, .rst_i, .ce_i, .io_state_i, .lamp_lit_i, .elem_operate_i,
    .io_word_sel_i(io_sel), .elem_word_sel_i(elem_sel), .io_word_o, .lamp_word_o, .elem_word_o);
  sbp_poller master_u (.clk_i, .rst_i, .io_sel_o(io_sel), .elem_sel_o(elem_sel));
  initial forever #20 clk_i = ~clk_i;
  task automatic summarize;
    if (num_errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #50000 num_errors++;
    summarize();
  end
  // Phases 0 and 1 hit the first and last bit of every map; phase 5 freezes
  initial
  begin
    void'($urandom(27));
    repeat (16) @(posedge clk_i);
    #1 rst_i = 0;
    for (int p = 0; p < 10; p++)
    begin
      io_state_i = p > 1 ? {$urandom, $urandom} : 64'h1 << 63 * p;
      lamp_lit_i = p > 1 ? 8'($urandom) : 8'h1 << 7 * p;
      elem_operate_i = p > 1 ? {8{$urandom}} : 256'h1 << 255 * p;
      ce_i = p != 5;
      for (int c = 0; c < 24; c++)
      begin
        @(posedge clk_i);
        #1 rv = {<<{io_state_i[16*io_sel +: 16]}};
        // The last word of the phase before the freeze lands on a disabled edge
        q.push_back('{c > 2 && p != 5 && (p != 4 || c < 23), rv, {8'h00, lamp_lit_i},
          elem_operate_i[16*elem_sel +: 16]});
      end
    end
    summarize();
  end
  always @(negedge clk_i)
    if (q.size() > 1)
    begin
      e = q.pop_front();
      if (e.v)
      begin
        `CHK("io_word", e.io, io_word_o)
        `CHK("lamp_word", e.lamp, lamp_word_o)
        `CHK("elem_word", e.elem, elem_word_o)
      end
    end
endmodule
`default_nettype wire

//--- sbp_word_mux.sv
// Word selector over a flat packed array of status words
`timescale 1ns/1ps
`default_nettype none
module sbp_word_mux #(
  parameter int unsigned WORDS = 16,
  parameter int unsigned IDX_W = 4
) (
  input wire logic [WORDS*sbp_pkg::WORD_W-1:0] words_i,
  input wire logic [IDX_W-1:0] idx_i,
  output logic [sbp_pkg::WORD_W-1:0] word_o
);
  always_comb
  begin
    word_o = sbp_pkg::WORD_RESET;
    if (32'(idx_i) < WORDS)
    begin
      word_o = words_i[32'(idx_i)*sbp_pkg::WORD_W +: sbp_pkg::WORD_W];
    end
  end
endmodule
`default_nettype wire
